// ### core/cpsc_core_fsm.sv
// Per-core low-power state machine
`timescale 1ns/1ps
`default_nettype none
`include "cpsc_cfg.svh"
module cpsc_core_fsm
    import cpsc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic i_enter,
    input wire logic [1:0] i_state,
    input wire logic i_by_reg,
    input wire logic i_wake_other,
    input wire logic i_wake_self,
    input wire logic i_disabled,
    output cpsc_core_ctl_t o_ctl,
    output logic [1:0] o_state
);
    cpsc_core_state_t st_ff, nxt_st;
    logic lock_ff, nxt_lock;
    logic [`CPSC_CNT_W-1:0] cnt_ff, nxt_cnt;
    cpsc_core_ctl_t ctl_ff, nxt_ctl;
    logic [1:0] pst_ff, nxt_pst;
    logic wake;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_lock = lock_ff;
        nxt_cnt = cnt_ff;
        // Register entry locks out self wake
        wake = i_wake_other | (i_wake_self & ~lock_ff);
        case (st_ff)
            CPSC_RUN: begin
                if (i_enter && i_state == `CPSC_STATE_HALT) begin
                    nxt_st = CPSC_HALT;
                    nxt_lock = i_by_reg;
                end else if (i_enter && i_state == `CPSC_STATE_NAP) begin
                    nxt_st = CPSC_NAP_DOWN;
                    nxt_lock = i_by_reg;
                    nxt_cnt = 7'h02;
                end
            end
            CPSC_HALT: begin
                if (wake) begin
                    nxt_st = CPSC_RUN;
                    nxt_lock = 1'b0;
                end
            end
            CPSC_NAP_DOWN: begin
                if (cnt_ff == 7'h00) begin
                    nxt_st = CPSC_NAP;
                end else begin
                    nxt_cnt = cnt_ff - 7'h01;
                end
            end
            CPSC_NAP: begin
                if (wake) begin
                    nxt_st = CPSC_NAP_UP;
                    nxt_cnt = 7'(`CPSC_NAP_RAMP_CLKS);
                    nxt_lock = 1'b0;
                end
            end
            CPSC_NAP_UP: begin
                if (cnt_ff == 7'h00) begin
                    nxt_st = CPSC_RUN;
                end else begin
                    nxt_cnt = cnt_ff - 7'h01;
                end
            end
            default: nxt_st = CPSC_RUN;
        endcase
        if (i_disabled) begin
            nxt_st = CPSC_RUN;
            nxt_lock = 1'b0;
        end
    end

    // ----------------------------------------
    // Controls per state
    // ----------------------------------------
    always_comb begin
        nxt_ctl = '{fetch_en: 1'b1, snoop_en: 1'b1, clk_en: 1'b1, retain: 1'b0, low_vdd: 1'b0};
        nxt_pst = `CPSC_STATE_RUN;
        case (nxt_st)
            CPSC_HALT: begin
                nxt_ctl.fetch_en = 1'b0;
                nxt_pst = `CPSC_STATE_HALT;
            end
            CPSC_NAP_DOWN, CPSC_NAP, CPSC_NAP_UP: begin
                nxt_ctl.fetch_en = 1'b0;
                nxt_ctl.snoop_en = 1'b0;
                nxt_ctl.clk_en = 1'b0;
                nxt_ctl.retain = 1'b1;
                nxt_ctl.low_vdd = (nxt_st == CPSC_NAP);
                nxt_pst = `CPSC_STATE_NAP;
            end
            default: ;
        endcase
        if (i_disabled) begin
            nxt_ctl = '0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            st_ff <= CPSC_RUN;
            lock_ff <= 1'b0;
            cnt_ff <= 7'h00;
            ctl_ff <= '{fetch_en: 1'b1, snoop_en: 1'b1, clk_en: 1'b1, retain: 1'b0, low_vdd: 1'b0};
            pst_ff <= `CPSC_STATE_RUN;
        end else if (i_ce) begin
            st_ff <= nxt_st;
            lock_ff <= nxt_lock;
            cnt_ff <= nxt_cnt;
            ctl_ff <= nxt_ctl;
            pst_ff <= nxt_pst;
        end
    end

    assign o_ctl = ctl_ff;
    assign o_state = pst_ff;
endmodule
`default_nettype wire

// ### core/cpsc_cfg.svh
// Constants of the core power state controller
`ifndef CPSC_CFG_SVH
`define CPSC_CFG_SVH
`define CPSC_NUM_CORES 4
`define CPSC_NUM_BLOCKS 8
`define CPSC_CLK_PERIOD_NS 25
`define CPSC_NAP_WAKE_CLKS 100
`define CPSC_NAP_RAMP_CLKS (`CPSC_NAP_WAKE_CLKS - 4)
`define CPSC_CNT_W 7
`define CPSC_STATE_RUN 2'h0
`define CPSC_STATE_HALT 2'h1
`define CPSC_STATE_NAP 2'h2
`endif

// ### core/cpsc_pkg.sv
// Types of the core power state controller
package cpsc_pkg;
    typedef enum logic [2:0] {
        CPSC_RUN = 3'b000,
        CPSC_HALT = 3'b001,
        CPSC_NAP_DOWN = 3'b010,
        CPSC_NAP = 3'b011,
        CPSC_NAP_UP = 3'b100
    } cpsc_core_state_t;
    typedef struct packed {
        logic valid;
        logic [1:0] core;
        logic [1:0] state;
        logic by_reg;
    } cpsc_req_t;
    typedef struct packed {
        logic fetch_en;
        logic snoop_en;
        logic clk_en;
        logic retain;
        logic low_vdd;
    } cpsc_core_ctl_t;
endpackage

// ### core/cpsc_top.sv
// Clock gating and core low-power state controller
`timescale 1ns/1ps
`default_nettype none
`include "cpsc_cfg.svh"
module cpsc_top
    import cpsc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic [`CPSC_NUM_BLOCKS-1:0] i_blk_busy,
    input wire logic [`CPSC_NUM_BLOCKS-1:0] i_blk_dispatch,
    input wire logic i_dis_we,
    input wire logic [`CPSC_NUM_BLOCKS-1:0] i_dis_blk,
    input wire logic [`CPSC_NUM_CORES-1:0] i_dis_core,
    input wire cpsc_req_t i_req,
    input wire logic [1:0] i_req_src,
    input wire logic [`CPSC_NUM_CORES-1:0] i_wr_perm,
    input wire logic [`CPSC_NUM_CORES-1:0] i_instr_halt,
    input wire logic [`CPSC_NUM_CORES-1:0] i_instr_nap,
    input wire logic [`CPSC_NUM_CORES-1:0] i_ext_wake,
    input wire logic [`CPSC_NUM_CORES-1:0] i_self_wake,
    output logic [`CPSC_NUM_BLOCKS-1:0] o_blk_clk_en,
    output logic [`CPSC_NUM_BLOCKS-1:0] o_blk_disabled,
    output cpsc_core_ctl_t [`CPSC_NUM_CORES-1:0] o_core_ctl,
    output logic [`CPSC_NUM_CORES*2-1:0] o_core_state
);
    logic [`CPSC_NUM_BLOCKS-1:0] bdis_ff, nxt_bdis;
    logic [`CPSC_NUM_CORES-1:0] cdis_ff, nxt_cdis;
    logic [`CPSC_NUM_BLOCKS-1:0] ben_ff, nxt_ben;
    logic [`CPSC_NUM_CORES-1:0] enter, by_reg, wake_other;
    logic [1:0] tgt_state [`CPSC_NUM_CORES];
    logic req_ok;

    // ----------------------------------------
    // Static disables and block gating
    // ----------------------------------------
    always_comb begin
        nxt_bdis = bdis_ff;
        nxt_cdis = cdis_ff;
        if (i_dis_we) begin
            nxt_bdis = bdis_ff | i_dis_blk;
            nxt_cdis = cdis_ff | i_dis_core;
        end
        // Clock runs while busy or on dispatch unless disabled; stops when idle
        nxt_ben = (i_blk_busy | i_blk_dispatch) & ~nxt_bdis;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            bdis_ff <= '0;
            cdis_ff <= '0;
            ben_ff <= '0;
        end else if (i_ce) begin
            bdis_ff <= nxt_bdis;
            cdis_ff <= nxt_cdis;
            ben_ff <= nxt_ben;
        end
    end

    // ----------------------------------------
    // Entry request decode
    // ----------------------------------------
    always_comb begin
        req_ok = i_req.valid & i_wr_perm[i_req_src];
        for (int c = 0; c < `CPSC_NUM_CORES; c++) begin
            enter[c] = 1'b0;
            by_reg[c] = 1'b0;
            wake_other[c] = i_ext_wake[c];
            tgt_state[c] = `CPSC_STATE_RUN;
            if (req_ok && i_req.core == 2'(c)) begin
                if (i_req.state == `CPSC_STATE_RUN) begin
                    wake_other[c] = wake_other[c] | (i_req_src != 2'(c));
                end else begin
                    enter[c] = 1'b1;
                    by_reg[c] = 1'b1;
                    tgt_state[c] = i_req.state;
                end
            end else if (i_instr_nap[c]) begin
                enter[c] = 1'b1;
                tgt_state[c] = `CPSC_STATE_NAP;
            end else if (i_instr_halt[c]) begin
                enter[c] = 1'b1;
                tgt_state[c] = `CPSC_STATE_HALT;
            end
        end
    end

    // ----------------------------------------
    // Per-core state machines
    // ----------------------------------------
    for (genvar g = 0; g < `CPSC_NUM_CORES; g++) begin : g_core
        cpsc_core_fsm u_fsm (
            .i_clk(i_clk),
            .i_rstn(i_rstn),
            .i_ce(i_ce),
            .i_enter(enter[g]),
            .i_state(tgt_state[g]),
            .i_by_reg(by_reg[g]),
            .i_wake_other(wake_other[g]),
            .i_wake_self(i_self_wake[g]),
            .i_disabled(cdis_ff[g]),
            .o_ctl(o_core_ctl[g]),
            .o_state(o_core_state[g*2 +: 2])
        );
    end

    assign o_blk_clk_en = ben_ff;
    assign o_blk_disabled = bdis_ff;
endmodule
`default_nettype wire

// ### test/cpsc_props.sv
// Port checks of the core power state controller
`timescale 1ns/1ps
`default_nettype none
module cpsc_props
    import cpsc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [7:0] i_blk_busy,
    input wire logic [7:0] i_blk_dispatch,
    input wire logic i_dis_we,
    input wire logic [7:0] i_dis_blk,
    input wire cpsc_req_t i_req,
    input wire logic [3:0] i_instr_halt,
    input wire logic [3:0] i_instr_nap,
    input wire logic [7:0] o_blk_clk_en,
    input wire logic [7:0] o_blk_disabled,
    input wire cpsc_core_ctl_t [3:0] o_core_ctl,
    input wire logic [7:0] o_core_state
);
    logic [3:0] halt_bad;
    logic [3:0] nap_bad;
    for (genvar c = 0; c < 4; c++) begin : g_core
        assign halt_bad[c] = o_core_state[c*2+:2] == 2'h1 && o_core_ctl[c] != 5'h0C;
        assign nap_bad[c] = o_core_state[c*2+:2] == 2'h2 && o_core_ctl[c][4:1] != 4'h1;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    idle_gate_a: assert property ($past(i_rstn) |-> (o_blk_clk_en & ~$past(i_blk_busy | i_blk_dispatch)) == 8'h00)
        else $error("idle block clocked");
    work_wake_a: assert property ($past(i_rstn) |-> ($past(i_blk_dispatch) & ~o_blk_disabled & ~o_blk_clk_en) == 8'h00)
        else $error("dispatched block not clocked");
    dis_gate_a: assert property (($past(o_blk_disabled) & o_blk_clk_en) == 8'h00)
        else $error("disabled block clocked");
    dis_set_a: assert property ($past(i_rstn) && $past(i_dis_we) |-> (o_blk_disabled & $past(i_dis_blk)) == $past(i_dis_blk))
        else $error("disable not taken");
    dis_keep_a: assert property ($past(i_rstn) |-> ($past(o_blk_disabled) & ~o_blk_disabled) == 8'h00)
        else $error("disable cleared");
    halt_ctl_a: assert property (halt_bad == 4'h0)
        else $error("halt controls wrong");
    nap_ctl_a: assert property (nap_bad == 4'h0)
        else $error("nap controls wrong");
    nap_wake_a: assert property ($fell(o_core_ctl[3].low_vdd) |-> ##[80:100] o_core_state[7:6] == 2'h0)
        else $error("nap wake too slow");
    instr_halt_a: assert property ($past(i_rstn) && $past(o_core_state[1:0] == 2'h0 && i_instr_halt[0]
        && !i_instr_nap[0] && !i_req.valid && o_core_ctl[0] != 5'h00) |-> o_core_state[1:0] == 2'h1)
        else $error("halt instruction ignored");
    cover property (o_core_state[7:6] == 2'h2);
    cover property (o_core_state[3:2] == 2'h1);
    cover property ($past(i_dis_we));
endmodule
`default_nettype wire

// ### test/cpsc_blk_model.sv
// Model of a gated logic block taking work
`timescale 1ns/1ps
`default_nettype none
module cpsc_blk_model (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [7:0] i_work,
    input wire logic [7:0] i_done,
    output logic [7:0] o_dispatch,
    output logic [7:0] o_busy
);
    // Work arrives as a pulse, block stays busy until done
    always_ff @(posedge i_clk) begin
        o_dispatch <= i_rstn ? i_work : 8'h00;
        o_busy <= i_rstn ? (o_busy | o_dispatch) & ~i_done : 8'h00;
    end
endmodule
`default_nettype wire

// ### test/cpsc_top_tb.sv
// Self-checking bench of the core power state controller
`timescale 1ns/1ps
`default_nettype none
module cpsc_top_tb import cpsc_pkg::*;;
    logic i_clk = 1'b0, i_rstn = 1'b0, dis_we = 1'b0, ce = 1'b1;
    logic [7:0] work = 8'h00, done = 8'h00, dis_blk = 8'h00, busy, disp, clk_en, blk_dis, state, st;
    logic [3:0] dis_core = 4'h0, perm = 4'hF;
    logic [15:0] cp = 16'h0000;
    logic [1:0] src = 2'h0;
    cpsc_req_t req = '0;
    cpsc_core_ctl_t [3:0] ctl;
    int num_errors = 0, n_compared = 0, seed = 32'h43E0, k;
    cpsc_blk_model i_blk (.i_clk(i_clk), .i_rstn(i_rstn), .i_work(work), .i_done(done), .o_dispatch(disp),
        .o_busy(busy));
    cpsc_top i_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(ce), .i_blk_busy(busy), .i_blk_dispatch(disp),
        .i_dis_we(dis_we), .i_dis_blk(dis_blk), .i_dis_core(dis_core), .i_req(req), .i_req_src(src),
        .i_wr_perm(perm), .i_instr_halt(cp[3:0]), .i_instr_nap(cp[7:4]), .i_ext_wake(cp[11:8]),
        .i_self_wake(cp[15:12]), .o_blk_clk_en(clk_en), .o_blk_disabled(blk_dis), .o_core_ctl(ctl),
        .o_core_state(state));
    function automatic logic [19:0] exp_ctl(logic [7:0] s);
        for (int c = 0; c < 4; c++) begin
            exp_ctl[c*5+:5] = s[c*2+:2] == 2'h1 ? 5'h0C : s[c*2+:2] == 2'h2 ? 5'h03 : 5'h1C;
        end
    endfunction
    task automatic chk(logic [19:0] got, logic [19:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cores;
        chk(state, st);
        chk(ctl, exp_ctl(st));
    endtask
    task automatic wr(logic [1:0] s, logic [1:0] c, logic [1:0] t);
        @(posedge i_clk) src <= s;
        req <= '{1'b1, c, t, 1'b1};
        @(posedge i_clk) req <= '0;
        #1;
    endtask
    task automatic pulse(logic [15:0] m);
        @(posedge i_clk) cp <= m;
        @(posedge i_clk) cp <= 16'h0000;
        #1;
    endtask
    task automatic give(logic [7:0] m);
        @(posedge i_clk) work <= m;
        @(posedge i_clk) work <= 8'h00;
        // Model delays dispatch by one cycle
        @(posedge i_clk);
        #1;
    endtask
    task automatic report_and_stop;
        if (num_errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        forever #12.5 i_clk = ~i_clk;
    end
    initial begin
        repeat (4000) @(posedge i_clk);
        num_errors++;
        report_and_stop();
    end
    initial begin
        repeat (3) @(posedge i_clk);
        i_rstn <= 1'b1;
        #1 st = 8'h00;
        chk({clk_en, blk_dis}, 16'h0000);
        cores();
        wr(0, 1, 1);
        st = 8'h04;
        cores();
        pulse(16'h2000);
        wr(1, 1, 0);
        cores();
        wr(0, 1, 0);
        st = 8'h00;
        cores();
        perm = 4'hE;
        wr(0, 2, 1);
        cores();
        perm = 4'hF;
        wr(2, 2, 1);
        st = 8'h10;
        cores();
        pulse(16'h0400);
        st = 8'h00;
        cores();
        pulse(16'h0001);
        st = 8'h01;
        cores();
        pulse(16'h1000);
        st = 8'h00;
        cores();
        for (int m = 0; m < 2; m++) begin
            if (m == 0) begin
                pulse(16'h0080);
            end else begin
                wr(0, 3, 2);
            end
            chk(ctl[3], 5'h02);
            repeat (3) @(posedge i_clk);
            #1 st = 8'h80;
            cores();
            pulse(16'h0800);
            for (k = 1; state[7:6] !== 2'h0 && k < 200; k++) @(posedge i_clk) #1;
            chk(k < 101, 1'b1);
        end
        repeat (300) @(posedge i_clk) begin
            work <= 8'($random(seed));
            done <= 8'($random(seed));
        end
        @(posedge i_clk) done <= 8'hFF;
        give(8'h00);
        chk(clk_en, 8'h00);
        give(8'h21);
        chk(clk_en, 8'h21);
        @(posedge i_clk) dis_we <= 1'b1;
        dis_blk <= 8'h21;
        dis_core <= 4'h4;
        @(posedge i_clk) dis_we <= 1'b0;
        give(8'h21);
        chk({clk_en, blk_dis}, {8'h00, 8'h21});
        chk(ctl[2], 5'h00);
        wr(0, 2, 1);
        chk(state, 8'h00);
        @(posedge i_clk) ce <= 1'b0;
        wr(0, 1, 1);
        chk(state, 8'h00);
        @(posedge i_clk) ce <= 1'b1;
        repeat (20) @(posedge i_clk);
        #1 chk(blk_dis, 8'h21);
        @(posedge i_clk) i_rstn <= 1'b0;
        @(posedge i_clk) i_rstn <= 1'b1;
        #1 chk(blk_dis, 8'h00);
        report_and_stop();
    end
endmodule
bind cpsc_top cpsc_props i_props (.i_clk, .i_rstn, .i_blk_busy, .i_blk_dispatch, .i_dis_we, .i_dis_blk, .i_req,
    .i_instr_halt, .i_instr_nap, .o_blk_clk_en, .o_blk_disabled, .o_core_ctl, .o_core_state);
`default_nettype wire
